/* common/rsc_defines.svh */
// Purpose: constants of the reset strap capture block
// Assumes: byte addresses on a 32-bit avalon-mm slave
// Notes:   definitions only
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define RSC_OFS_ACCESS_RB 4'h0
`define RSC_OFS_UPLINK_RB 4'h4
`define RSC_OFS_CONFIG 4'h8
`define RSC_OFS_CONTROL 4'hc

// ==========================================================
// field positions in the config status word
`define RSC_F_DEBOUNCE 0
`define RSC_F_MODE_LO 1
`define RSC_F_ID_LO 4
`define RSC_F_EEPROM_ABSENT 7
`define RSC_F_MODULE_DETECT 9
`define RSC_F_POWER_SAVE 11
`define RSC_F_TIMEOUT_RESET 12
`define RSC_F_VALID 16

// field positions in the control word
`define RSC_F_ID_OVR_LO 0
`define RSC_F_ID_OVR_EN 3

// ==========================================================
// reset values
`define RSC_CONTROL_RST 4'h0
`define RSC_READ_RST 32'h0000_0000

// ==========================================================
// timing: strobe must hold steady this long to be accepted
`define RSC_CLK_NS 100
`define RSC_DEBOUNCE_NS 1000
`define RSC_DEBOUNCE_CYC ((`RSC_DEBOUNCE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)

`endif

/* common/rsc_pkg.sv */
// Purpose: types of the reset strap capture block
// Assumes: nothing
// Notes:   mode codes equal the three mode strap levels for 000 to 011 only

package rsc_pkg;
   // ==========================================================
   // management interface modes as decoded from the straps
   typedef enum logic [2:0] {
      RSC_MODE_PAR16,
      RSC_MODE_PAR8,
      RSC_MODE_SER_MII,
      RSC_MODE_SER_ONLY,
      RSC_MODE_SER_UNMANAGED,
      RSC_MODE_RESERVED
   } rsc_mode_t;
endpackage

/* src/rsc_debounce.sv */
// Purpose: optional debounce filter for the management strobe
// Assumes: strobe input already synchronous to clk
// Notes:   bypass is a pure wire, so no latency when disabled
`timescale 1ns/1ps
`default_nettype none

module rsc_debounce #(
   parameter int CYCLES = 10
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic strobe_raw,
   output logic strobe_out
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count_r;
   logic filt_r;
   wire differs = strobe_raw != filt_r;
   wire settled = count_r == CW'(CYCLES - 1);

   // ==========================================================
   // filter: new level accepted only after CYCLES steady samples
   always_ff @(posedge clk) begin
      if (!rstn) begin
         count_r <= '0;
         filt_r <= 1'b0;
      end else if (!differs) begin
         count_r <= '0;
      end else if (settled) begin
         count_r <= '0;
         filt_r <= strobe_raw;
      end else begin
         count_r <= count_r + CW'(1);
      end
   end

   // bypass when the debounce strap was low
   assign strobe_out = enable ? filt_r : strobe_raw; // RULE2
endmodule

`default_nettype wire

/* src/rsc_shared_pin.sv */
// Purpose: capture straps on pins shared with port outputs
// Assumes: synchronous active-low reset; pins read while it is low
// Notes:   one instance per group of shared pins
`timescale 1ns/1ps
`default_nettype none

module rsc_shared_pin #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] pin_in,
   input wire logic [W-1:0] func_out,
   input wire logic [W-1:0] func_oe,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe,
   output logic [W-1:0] strap_val
);
   logic [W-1:0] strap_r;
   logic live_r;

   // ==========================================================
   // sample every cycle of reset; last sample before release sticks
   always_ff @(posedge clk) begin
      if (!rstn) begin
         strap_r <= pin_in; // RULE1
         live_r <= 1'b0;
      end else begin
         live_r <= 1'b1;
      end
   end

   // pins stay inputs until the straps are latched
   assign pin_oe = live_r ? func_oe : '0; // RULE14
   assign pin_out = live_r ? func_out : '0; // RULE14
   assign strap_val = strap_r;
endmodule

`default_nettype wire

/* src/rsc_top.sv */
// Purpose: reset strap capture and static configuration decode
// Assumes: straps driven by board resistors while rstn is low
// Notes:   registers reached over avalon-mm with waitrequest
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.svh"

// Behaviour
// RULE1 - sample all straps during reset, hold the last value until next reset
// RULE2 - debounce strobe when debounce strap high, pass it straight when low
// RULE3 - three mode straps, lowest is lsb: 000 par16, 001 par8, 010, 011, 111
// RULE4 - serial-only mode lets the host send and receive serial frames
// RULE5 - unmanaged serial refuses serial frames but may boot from eeprom
// RULE6 - default serial address comes from three identifier straps
// RULE7 - identifier lowest strap is lsb, high strap reads as one
// RULE8 - high eeprom strap means no eeprom fitted, low means one present
// RULE9 - module-detect strap high enables phy presence detection
// RULE10 - power-saving strap high enables mac power saving
// RULE11 - timeout-reset strap high enables timeout-triggered reset
// RULE12 - eight access-port straps captured and readable by software
// RULE13 - two uplink straps captured and readable in a second register
// RULE14 - shared strap pins are inputs in reset, normal only after latch
module rsc_top #(
   parameter int DEBOUNCE_CYCLES = `RSC_DEBOUNCE_CYC,
   parameter int ACCESS_PORTS = 8,
   parameter int UPLINK_STRAPS = 2
) (
   input wire logic clk,
   input wire logic rstn,
   // dedicated strap pins
   input wire logic strobe_debounce_strap,
   input wire logic [2:0] mgmt_mode_straps,
   input wire logic [2:0] serial_id_straps,
   input wire logic eeprom_absent_strap,
   input wire logic module_detect_strap,
   input wire logic mac_power_save_strap,
   input wire logic timeout_reset_strap,
   // shared access-port transmit-enable pins
   input wire logic [ACCESS_PORTS-1:0] access_port_user_straps,
   input wire logic [ACCESS_PORTS-1:0] access_txen_func,
   input wire logic [ACCESS_PORTS-1:0] access_txen_func_oe,
   output logic [ACCESS_PORTS-1:0] access_txen_pin_out,
   output logic [ACCESS_PORTS-1:0] access_txen_pin_oe,
   // shared uplink pins: bit 0 transmit enable, bit 1 transmit error
   input wire logic uplink_user_strap_a,
   input wire logic uplink_user_strap_b,
   input wire logic [UPLINK_STRAPS-1:0] uplink_func,
   input wire logic [UPLINK_STRAPS-1:0] uplink_func_oe,
   output logic [UPLINK_STRAPS-1:0] uplink_pin_out,
   output logic [UPLINK_STRAPS-1:0] uplink_pin_oe,
   // management strobe
   input wire logic mgmt_strobe_in,
   output logic mgmt_strobe_out,
   // decoded configuration
   output rsc_pkg::rsc_mode_t mgmt_mode,
   output logic mgmt_parallel,
   output logic mgmt_bus_16bit,
   output logic mii_frame_path_en,
   output logic serial_frame_tx_en,
   output logic serial_frame_rx_en,
   output logic eeprom_present,
   output logic eeprom_boot_en,
   output logic [2:0] serial_dev_id,
   output logic phy_detect_en,
   output logic mac_power_save_en,
   output logic timeout_reset_en,
   output logic straps_valid,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import rsc_pkg::*;

   // ==========================================================
   // strap capture for dedicated pins
   logic debounce_r;
   logic [2:0] mode_r;
   logic [2:0] id_r;
   logic eeprom_absent_r;
   logic module_detect_r;
   logic power_save_r;
   logic timeout_reset_r;
   logic valid_r;

   // synchronous reset lets the flops follow the pins while held;
   // the value seen on the last reset edge is what stays
   always_ff @(posedge clk) begin
      if (!rstn) begin
         debounce_r <= strobe_debounce_strap; // RULE1
         mode_r <= mgmt_mode_straps; // RULE1
         id_r <= serial_id_straps; // RULE7
         eeprom_absent_r <= eeprom_absent_strap; // RULE1
         module_detect_r <= module_detect_strap; // RULE1
         power_save_r <= mac_power_save_strap; // RULE1
         timeout_reset_r <= timeout_reset_strap; // RULE1
         valid_r <= 1'b0;
      end else begin
         valid_r <= 1'b1;
      end
   end

   assign straps_valid = valid_r;

   // ==========================================================
   // shared pins: capture and output gating
   logic [ACCESS_PORTS-1:0] access_straps;
   logic [UPLINK_STRAPS-1:0] uplink_straps;
   wire [UPLINK_STRAPS-1:0] uplink_pins_in =
      {uplink_user_strap_b, uplink_user_strap_a};

   rsc_shared_pin #(
      .W(ACCESS_PORTS)
   ) u_access_pins (
      .clk(clk),
      .rstn(rstn),
      .pin_in(access_port_user_straps), // RULE12
      .func_out(access_txen_func),
      .func_oe(access_txen_func_oe),
      .pin_out(access_txen_pin_out),
      .pin_oe(access_txen_pin_oe),
      .strap_val(access_straps)
   );

   rsc_shared_pin #(
      .W(UPLINK_STRAPS)
   ) u_uplink_pins (
      .clk(clk),
      .rstn(rstn),
      .pin_in(uplink_pins_in), // RULE13
      .func_out(uplink_func),
      .func_oe(uplink_func_oe),
      .pin_out(uplink_pin_out),
      .pin_oe(uplink_pin_oe),
      .strap_val(uplink_straps)
   );

   // ==========================================================
   // strobe conditioning
   rsc_debounce #(
      .CYCLES(DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk(clk),
      .rstn(rstn),
      .enable(debounce_r), // RULE2
      .strobe_raw(mgmt_strobe_in),
      .strobe_out(mgmt_strobe_out)
   );

   // ==========================================================
   // management mode decode; codes 100..110 have no meaning and
   // fall into reserved, which enables no frame path at all
   rsc_mode_t mode_dec;

   always_comb begin
      unique case (mode_r) // RULE3
         3'h0: mode_dec = RSC_MODE_PAR16;
         3'h1: mode_dec = RSC_MODE_PAR8;
         3'h2: mode_dec = RSC_MODE_SER_MII;
         3'h3: mode_dec = RSC_MODE_SER_ONLY;
         3'h7: mode_dec = RSC_MODE_SER_UNMANAGED;
         default: mode_dec = RSC_MODE_RESERVED;
      endcase
   end

   wire is_par16 = mode_dec == RSC_MODE_PAR16;
   wire is_par8 = mode_dec == RSC_MODE_PAR8;
   wire is_ser_mii = mode_dec == RSC_MODE_SER_MII;
   wire is_ser_only = mode_dec == RSC_MODE_SER_ONLY;
   wire is_unmanaged = mode_dec == RSC_MODE_SER_UNMANAGED;

   // decoded enables below, not mgmt_mode, are gated by valid so nothing acts during reset
   assign mgmt_mode = mode_dec;
   assign mgmt_parallel = valid_r & (is_par16 | is_par8); // RULE3
   assign mgmt_bus_16bit = valid_r & is_par16; // RULE3
   assign mii_frame_path_en = valid_r & is_ser_mii; // RULE3
   // only serial-only mode carries host frames over the serial bus
   assign serial_frame_tx_en = valid_r & is_ser_only; // RULE4 RULE5
   assign serial_frame_rx_en = valid_r & is_ser_only; // RULE4 RULE5

   // ==========================================================
   // eeprom and feature enables
   assign eeprom_present = ~eeprom_absent_r; // RULE8
   // boot load only makes sense unmanaged and with a device fitted
   assign eeprom_boot_en = valid_r & is_unmanaged & ~eeprom_absent_r; // RULE5
   assign phy_detect_en = valid_r & module_detect_r; // RULE9
   assign mac_power_save_en = valid_r & power_save_r; // RULE10
   assign timeout_reset_en = valid_r & timeout_reset_r; // RULE11

   // ==========================================================
   // control register: software may replace the strapped address
   logic [3:0] control_r;
   wire id_ovr_en = control_r[`RSC_F_ID_OVR_EN];
   wire [2:0] id_ovr = control_r[`RSC_F_ID_OVR_LO +: 3];

   // strapped id is the default until software overrides it
   assign serial_dev_id = id_ovr_en ? id_ovr : id_r; // RULE6

   // ==========================================================
   // avalon-mm slave: one wait state on every access
   logic ack_r;
   logic [31:0] rdata_r;
   wire req = avs_read | avs_write;
   wire sel_access = avs_address == `RSC_OFS_ACCESS_RB;
   wire sel_uplink = avs_address == `RSC_OFS_UPLINK_RB;
   wire sel_config = avs_address == `RSC_OFS_CONFIG;
   wire sel_control = avs_address == `RSC_OFS_CONTROL;
   wire wr_take = avs_write & ack_r & sel_control & avs_byteenable[0];

   // read words, unused bits zero
   wire [31:0] rd_access = {{(32 - ACCESS_PORTS){1'b0}}, access_straps};
   wire [31:0] rd_uplink = {{(32 - UPLINK_STRAPS){1'b0}}, uplink_straps};
   logic [31:0] rd_config;

   always_comb begin
      rd_config = 32'h0000_0000;
      rd_config[`RSC_F_DEBOUNCE] = debounce_r;
      rd_config[`RSC_F_MODE_LO +: 3] = mode_r;
      rd_config[`RSC_F_ID_LO +: 3] = id_r;
      rd_config[`RSC_F_EEPROM_ABSENT] = eeprom_absent_r;
      rd_config[`RSC_F_MODULE_DETECT] = module_detect_r;
      rd_config[`RSC_F_POWER_SAVE] = power_save_r;
      rd_config[`RSC_F_TIMEOUT_RESET] = timeout_reset_r;
      rd_config[`RSC_F_VALID] = valid_r;
   end

   // unmapped addresses read as zero and ignore writes
   wire [31:0] rd_mux =
      sel_access ? rd_access : // RULE12
      sel_uplink ? rd_uplink : // RULE13
      sel_config ? rd_config :
      sel_control ? {28'h000_0000, control_r} :
      `RSC_READ_RST;

   // ack alternates so a held request completes every second edge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ack_r <= 1'b0;
         rdata_r <= `RSC_READ_RST;
      end else begin
         ack_r <= req & ~ack_r;
         rdata_r <= (avs_read & ~ack_r) ? rd_mux : rdata_r;
      end
   end

   // control write lands on the edge where waitrequest is low
   always_ff @(posedge clk) begin
      if (!rstn) begin
         control_r <= `RSC_CONTROL_RST;
      end else if (wr_take) begin
         control_r <= avs_writedata[3:0];
      end
   end

   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata = rdata_r;
endmodule

`default_nettype wire

/* testbench/rsc_board.sv */
// Purpose: board pull resistors on the strap and shared pins
// Assumes: a shared pin shows its resistor unless the block drives it
// Notes:   resistors stay fitted after reset, so the block must ignore them
`timescale 1ns/1ps
`default_nettype none

module rsc_board (
   input wire logic [10:0] pull_cfg,
   input wire logic [9:0] pull_sh,
   input wire logic [9:0] sh_out,
   input wire logic [9:0] sh_oe,
   output logic [10:0] strap_lvl,
   output logic [9:0] sh_lvl
);
   // ==========================================================
   // pin levels
   // dedicated strap pins only ever see their resistor
   assign strap_lvl = pull_cfg;
   // a driving block beats the resistor on the shared pins
   assign sh_lvl = (sh_oe & sh_out) | (~sh_oe & pull_sh);
endmodule

`default_nettype wire

/* testbench/rsc_top_sva.sv */
// Purpose: port assertions for the strap capture block
// Assumes: rstn held low for at least one edge per reset
// Notes:   cap_r mirrors what the block should latch
`timescale 1ns/1ps
`default_nettype none

module rsc_top_sva #(
   parameter int ACCESS_PORTS = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic strobe_debounce_strap,
   input wire logic eeprom_absent_strap,
   input wire logic module_detect_strap,
   input wire logic mac_power_save_strap,
   input wire logic timeout_reset_strap,
   input wire logic [ACCESS_PORTS-1:0] access_txen_func_oe,
   input wire logic [ACCESS_PORTS-1:0] access_txen_pin_oe,
   input wire logic mgmt_strobe_in,
   input wire logic mgmt_strobe_out,
   input wire rsc_pkg::rsc_mode_t mgmt_mode,
   input wire logic mgmt_parallel,
   input wire logic mii_frame_path_en,
   input wire logic serial_frame_tx_en,
   input wire logic serial_frame_rx_en,
   input wire logic eeprom_present,
   input wire logic eeprom_boot_en,
   input wire logic phy_detect_en,
   input wire logic mac_power_save_en,
   input wire logic timeout_reset_en,
   input wire logic straps_valid,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   import rsc_pkg::*;
   logic [4:0] cap_r;
   // ==========================================================
   // reference capture, frozen once reset lets go
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cap_r <= {timeout_reset_strap, mac_power_save_strap,
            module_detect_strap, eeprom_absent_strap, strobe_debounce_strap};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ==========================================================
   // assertions
   valid_rise_a:
      assert property ($rose(rstn) |-> !straps_valid ##1 straps_valid)
      else $error("straps_valid timing wrong");
   strobe_bypass_a:
      assert property (straps_valid && !cap_r[0] |->
         mgmt_strobe_out == mgmt_strobe_in)
      else $error("strobe not passed straight");
   mode_paths_a:
      assert property (straps_valid |-> mgmt_parallel ==
         (mgmt_mode inside {RSC_MODE_PAR16, RSC_MODE_PAR8}) &&
         mii_frame_path_en == (mgmt_mode == RSC_MODE_SER_MII) &&
         serial_frame_tx_en == (mgmt_mode == RSC_MODE_SER_ONLY) &&
         serial_frame_rx_en == (mgmt_mode == RSC_MODE_SER_ONLY))
      else $error("mode paths wrong");
   unmanaged_boot_a:
      assert property (eeprom_boot_en == (straps_valid && eeprom_present &&
         mgmt_mode == RSC_MODE_SER_UNMANAGED))
      else $error("eeprom boot enable wrong");
   eeprom_sense_a:
      assert property (straps_valid |-> eeprom_present != cap_r[1])
      else $error("eeprom presence wrong");
   feature_en_a:
      assert property ({timeout_reset_en, mac_power_save_en, phy_detect_en}
         == (straps_valid ? cap_r[4:2] : 3'h0))
      else $error("feature enables wrong");
   pins_gated_a:
      assert property (access_txen_pin_oe == (straps_valid ?
         access_txen_func_oe : {ACCESS_PORTS{1'b0}}))
      else $error("shared pin driven early");
   one_wait_a:
      assert property ($rose(avs_read || avs_write) |->
         avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus wait state wrong");
endmodule

bind rsc_top rsc_top_sva #(.ACCESS_PORTS(ACCESS_PORTS)) u_sva (.*);

`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the strap capture block
// Assumes: board model supplies every strap and shared pin level
// Notes:   debounce count cut to 2 to keep strobe cases short
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import rsc_pkg::*;
   typedef struct packed {
      logic [10:0] cfg;
      logic [9:0] sh;
      rsc_mode_t mode;
      logic [5:0] fl;
   } rsc_row_t;
   logic clk, rstn, strb, strb_o, sv, eep, rd, wr, wait_o;
   logic [10:0] cfg, lvl;
   logic [9:0] sh, shl, fo, foe;
   wire [9:0] po, poe;
   wire [5:0] fl;
   wire [2:0] en;
   logic [2:0] id;
   rsc_mode_t mode;
   logic [3:0] adr, be;
   logic [31:0] wd, rdat, v, x;
   int bad_count, checks;
   rsc_row_t rows [9];
   rsc_row_t r;

   rsc_board BRD (.pull_cfg(cfg), .pull_sh(sh), .sh_out(po), .sh_oe(poe),
      .strap_lvl(lvl), .sh_lvl(shl));
   rsc_top #(.DEBOUNCE_CYCLES(2)) DUT (
      .clk(clk), .rstn(rstn), .strobe_debounce_strap(lvl[0]),
      .mgmt_mode_straps(lvl[3:1]), .serial_id_straps(lvl[6:4]),
      .eeprom_absent_strap(lvl[7]), .module_detect_strap(lvl[8]),
      .mac_power_save_strap(lvl[9]), .timeout_reset_strap(lvl[10]),
      .access_port_user_straps(shl[7:0]), .access_txen_func(fo[7:0]),
      .access_txen_func_oe(foe[7:0]), .access_txen_pin_out(po[7:0]),
      .access_txen_pin_oe(poe[7:0]), .uplink_user_strap_a(shl[8]),
      .uplink_user_strap_b(shl[9]), .uplink_func(fo[9:8]),
      .uplink_func_oe(foe[9:8]), .uplink_pin_out(po[9:8]),
      .uplink_pin_oe(poe[9:8]), .mgmt_strobe_in(strb),
      .mgmt_strobe_out(strb_o), .mgmt_mode(mode), .mgmt_parallel(fl[5]),
      .mgmt_bus_16bit(fl[4]), .mii_frame_path_en(fl[3]),
      .serial_frame_tx_en(fl[2]), .serial_frame_rx_en(fl[1]),
      .eeprom_present(eep), .eeprom_boot_en(fl[0]), .serial_dev_id(id),
      .phy_detect_en(en[0]), .mac_power_save_en(en[1]),
      .timeout_reset_en(en[2]), .straps_valid(sv), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_o));

   // ==========================================================
   // helpers
   task automatic summarize();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one avalon access; request held until waitrequest seen low
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge clk);
      adr <= a;
      wd <= d;
      be <= b;
      rd <= !w;
      wr <= w;
      n = 0;
      // waitrequest and read data are both taken at the rising edge
      do begin
         @(posedge clk);
         n++;
      end while (wait_o !== 1'b0 && n < 20);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wait_o !== 1'b0) begin
         bad_count++;
         summarize();
      end
   endtask
   // called just after a rising edge; holds rstn low for two edges
   task automatic reset_dut();
      rstn <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk(sv, 1'b0);
      chk({po, poe}, 20'h0);
      chk(rdat, 32'h0);
      @(posedge clk);
      rstn <= 1'b1;
   endtask
   task automatic strobe(input logic val, input int n);
      @(posedge clk);
      strb <= val;
      repeat (n - 1) @(posedge clk);
      @(negedge clk);
   endtask

   // ==========================================================
   // clock and main sequence
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      strb = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 4'h0;
      be = 4'h0;
      wd = 32'h0;
      cfg = 11'h0;
      sh = 10'h0;
      fo = 10'h0;
      foe = 10'h0;
      bad_count = 0;
      checks = 0;
      rows[0] = '{11'h080, 10'h2a5, RSC_MODE_PAR16, 6'h30};
      rows[1] = '{11'h753, 10'h15a, RSC_MODE_PAR8, 6'h20};
      rows[2] = '{11'h2a4, 10'h0ff, RSC_MODE_SER_MII, 6'h08};
      rows[3] = '{11'h537, 10'h300, RSC_MODE_SER_ONLY, 6'h06};
      rows[4] = '{11'h17e, 10'h3c3, RSC_MODE_SER_UNMANAGED, 6'h01};
      rows[5] = '{11'h4ef, 10'h001, RSC_MODE_SER_UNMANAGED, 6'h00};
      rows[6] = '{11'h60a, 10'h2d2, RSC_MODE_RESERVED, 6'h00};
      rows[7] = '{11'h18c, 10'h033, RSC_MODE_RESERVED, 6'h00};
      rows[8] = '{11'h348, 10'h1e0, RSC_MODE_RESERVED, 6'h00};
      foreach (rows[i]) begin
         r = rows[i];
         @(posedge clk);
         cfg <= r.cfg;
         sh <= r.sh;
         fo <= r.sh ^ 10'h3c3;
         foe <= ~r.sh;
         reset_dut();
         // flip every resistor: latched values must not follow
         @(posedge clk);
         cfg <= ~r.cfg;
         sh <= ~r.sh;
         @(negedge clk);
         chk(mode, r.mode);
         chk(fl, r.fl);
         chk(en, r.cfg[10:8]);
         chk(eep, !r.cfg[7]);
         chk(id, r.cfg[6:4]);
         chk(poe, foe);
         chk(po, fo);
         bus(1'b0, 4'h0, 32'h0, 4'hf, v);
         chk(v, {24'h0, r.sh[7:0]});
         bus(1'b0, 4'h4, 32'h0, 4'hf, v);
         chk(v, {30'h0, r.sh[9:8]});
         bus(1'b0, 4'h8, 32'h0, 4'hf, v);
         x = {15'h0, 1'b1, 3'h0, r.cfg[10:9], 1'b0, r.cfg[8], 1'b0,
            r.cfg[7:0]};
         chk(v, x);
         strobe(1'b1, 1);
         chk(strb_o, !r.cfg[0]);
         strobe(1'b0, 4);
         chk(strb_o, 1'b0);
         strobe(1'b1, 6);
         chk(strb_o, 1'b1);
         strobe(1'b0, 6);
         $display("row %0d done", i);
      end
      // id override, then writes that must be dropped
      bus(1'b1, 4'hc, 32'hd, 4'h1, v);
      bus(1'b1, 4'hc, 32'h3, 4'h0, v);
      bus(1'b1, 4'h0, 32'hff, 4'hf, v);
      @(negedge clk);
      chk(id, 3'h5);
      bus(1'b0, 4'h0, 32'h0, 4'hf, v);
      chk(v, 32'he0);
      bus(1'b0, 4'h1, 32'h0, 4'hf, v);
      chk(v, 32'h0);
      // second reset picks up the flipped resistors, drops override
      reset_dut();
      @(posedge clk);
      @(negedge clk);
      chk(id, 3'h3);
      chk(mode, RSC_MODE_SER_ONLY);
      $display("bus and re-reset cases done");
      summarize();
   end
endmodule

`default_nettype wire
